// File: common/gate_drive_defs.vh
// Constants for the gate-drive pulse mode block.
// Assumes inclusion by bare name from design files; definitions only.
// Functional notes
// - Filtered trigger active starts delay generator two cycles later.
// - After two delay high pulses: stop delay, start output, gate active.
// - Output generator finishes one high period, gate returns inactive.
// - Normal mode: trigger inactive stops output and forces gate inactive.
// - Gate signal passes one extra clock before the timer output pin.
// - Hold option set: trigger deassertion ignored while a gate is active.
// - Hold option set: trigger deasserting with gates inactive stops all.
// - Trigger dropping during delay stage stops before gate goes active.
// - Two channels with hold: ignore trigger while either gate active.
// - Control bit 1 selects trigger polarity, 0 high, 1 low.
// - Bits 3:2 give per-channel output polarity, 1 means active low.
// - Trigger pin synchronised by doubled peripheral clock before filter.
// - Filter counts up on opposite samples, down on matching; flips at width.
// - Width code 000 none, 001 4, 010 8, 011 16, 100 32 cycles.
// - Pin to filter delay 2-3, 5-6, 9-10, 17-18, 33-34 cycles.
// - Control bit 0 enables gate-drive mode.
// - Control bit 7 selects stop prohibition while an output is active.
`ifndef GATE_DRIVE_DEFS_VH
`define GATE_DRIVE_DEFS_VH

// Register map
`define GD_ADDR_CTRL     4'h0
`define GD_ADDR_DLY0_H   4'h1
`define GD_ADDR_DLY0_L   4'h2
`define GD_ADDR_OUT0_H   4'h3
`define GD_ADDR_OUT0_L   4'h4
`define GD_ADDR_DLY1_H   4'h5
`define GD_ADDR_DLY1_L   4'h6
`define GD_ADDR_OUT1_H   4'h7
`define GD_ADDR_OUT1_L   4'h8
`define GD_ADDR_RUN      4'h9
`define GD_ADDR_STATUS   4'ha

// Control register fields
`define GD_CTRL_RESET    8'h00
`define GD_MODE_BIT      0
`define GD_TRIG_POL_BIT  1
`define GD_OPOL_LSB      2
`define GD_FW_LSB        4
`define GD_HOLD_BIT      7

// Width and timing
`define GD_WIDTH_RESET   16'h0002
`define GD_DLY_PULSES    2'h2
`define GD_START_LAT     2'h2

// Filter thresholds per width code
`define GD_FW_LIM_NONE   6'd0
`define GD_FW_LIM_4      6'd4
`define GD_FW_LIM_8      6'd8
`define GD_FW_LIM_16     6'd16
`define GD_FW_LIM_32     6'd32

`endif

// File: hdl/gate_drive_pulse_mode.v
// Gate-drive pulse mode: trigger filter plus delay/output pulse pairs.
// Assumes a simple strobe register port and asynchronous trigger input.
`timescale 1ns/1ns
`include "gate_drive_defs.vh"

module gate_drive_pulse_mode
#(
	parameter WIDTH = 16
)
(
	input  wire        clk_i,
	input  wire        rst_n_i,
	input  wire [3:0]  addr_i,
	input  wire [15:0] wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output reg  [15:0] rdata_o,
	input  wire        trigger_input_pin_i,
	output reg         gate_out0_o,
	output reg         gate_out1_o
);

	// Channel states
	localparam ST_IDLE  = 2'd0;
	localparam ST_START = 2'd1;
	localparam ST_DLY   = 2'd2;
	localparam ST_OUT   = 2'd3;

	// Count value that ends a low, high or output phase
	localparam [WIDTH-1:0] CNT_ONE = {{(WIDTH-1){1'b0}}, 1'b1};

	// Filter threshold by width code
	function [5:0] fw_limit;
		input [2:0] code;
		begin
			case (code)
				3'd1:    fw_limit = `GD_FW_LIM_4;
				3'd2:    fw_limit = `GD_FW_LIM_8;
				3'd3:    fw_limit = `GD_FW_LIM_16;
				3'd4:    fw_limit = `GD_FW_LIM_32;
				default: fw_limit = `GD_FW_LIM_NONE;
			endcase
		end
	endfunction

	// Phase still running while more than one count remains
	function more_left;
		input [WIDTH-1:0] n;
		begin
			more_left = (n > CNT_ONE);
		end
	endfunction

	// Address falls in the width register window
	function is_width_addr;
		input [3:0] a;
		begin
			is_width_addr = (a >= `GD_ADDR_DLY0_H) &&
				(a <= `GD_ADDR_OUT1_L);
		end
	endfunction

	// Width register slot for a window address
	function [2:0] width_slot;
		input [3:0] a;
		begin
			width_slot = a[2:0] - 3'd1;
		end
	endfunction

	reg [7:0]       gate_mode_ctrl_q;
	reg [WIDTH-1:0] width_q [0:7];
	reg [1:0]       run_q;
	reg             sync1_q;
	reg             sync2_q;
	reg             filt_q;
	reg [5:0]       fcnt_q;
	reg [1:0]       st_q [0:1];
	reg [1:0]       lat_q [0:1];
	reg [WIDTH-1:0] cnt_q [0:1];
	reg             hi_q [0:1];
	reg [1:0]       pulses_q [0:1];
	reg [1:0]       gate_q;
	// Next values of the channel sequencers
	reg [1:0]       st_d [0:1];
	reg [1:0]       lat_d [0:1];
	reg [WIDTH-1:0] cnt_d [0:1];
	reg             hi_d [0:1];
	reg [1:0]       pulses_d [0:1];
	reg [1:0]       gate_d;
	integer         i;
	integer         j;
	integer         k;

	wire       mode_en    = gate_mode_ctrl_q[`GD_MODE_BIT];
	wire       trig_pol   = gate_mode_ctrl_q[`GD_TRIG_POL_BIT];
	wire [1:0] opol       = gate_mode_ctrl_q[`GD_OPOL_LSB+1:`GD_OPOL_LSB];
	wire [2:0] fw_sel     = gate_mode_ctrl_q[`GD_FW_LSB+2:`GD_FW_LSB];
	wire       hold       = gate_mode_ctrl_q[`GD_HOLD_BIT];
	wire [5:0] flim       = fw_limit(fw_sel);
	wire       trig_on    = filt_q ^ trig_pol;
	wire       any_active = gate_q[0] | gate_q[1];
	// Hold suppresses stopping while any gate is active
	wire       keep       = hold & any_active;
	wire       stop       = ~trig_on & ~keep;

	// Register writes
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			gate_mode_ctrl_q <= `GD_CTRL_RESET;
			run_q            <= 2'b00;
			for (i = 0; i < 8; i = i + 1)
				width_q[i] <= `GD_WIDTH_RESET;
		end
		else if (wr_i)
		begin
			case (addr_i)
				`GD_ADDR_CTRL:   gate_mode_ctrl_q <= wdata_i[7:0];
				`GD_ADDR_RUN:    run_q <= wdata_i[1:0];
				default:
				begin
					if (is_width_addr(addr_i))
						width_q[width_slot(addr_i)] <= wdata_i[WIDTH-1:0];
				end
			endcase
		end
	end

	// Read data, one cycle after the strobe
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
			rdata_o <= 16'h0000;
		else if (rd_i)
		begin
			case (addr_i)
				`GD_ADDR_CTRL:   rdata_o <= {8'h00, gate_mode_ctrl_q};
				`GD_ADDR_RUN:    rdata_o <= {14'h0000, run_q};
				`GD_ADDR_STATUS: rdata_o <= {9'h000, filt_q, st_q[1],
					st_q[0], gate_q};
				default:
				begin
					if (is_width_addr(addr_i))
						rdata_o <= width_q[width_slot(addr_i)];
					else
						rdata_o <= 16'h0000;
				end
			endcase
		end
		else
			rdata_o <= 16'h0000;
	end

	// Two-stage pin synchroniser feeding the filter
	// Only the second stage is read; the first may be metastable
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end
		else
		begin
			sync1_q <= trigger_input_pin_i;
			sync2_q <= sync1_q;
		end
	end

	// Up/down noise filter; code 000 passes straight through
	// Opposite samples count up, matching ones count down
	// Short glitches thus decay instead of accumulating
	// Prohibited codes behave as no filtering
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			filt_q <= 1'b0;
			fcnt_q <= 6'd0;
		end
		else if (flim == 6'd0)
		begin
			filt_q <= sync2_q;
			fcnt_q <= 6'd0;
		end
		else if (sync2_q != filt_q)
		begin
			if (fcnt_q + 6'd1 >= flim)
			begin
				filt_q <= ~filt_q;
				fcnt_q <= 6'd0;
			end
			else
				fcnt_q <= fcnt_q + 6'd1;
		end
		else if (fcnt_q != 6'd0)
			fcnt_q <= fcnt_q - 6'd1;
	end

	// Per-channel delay then output sequencer, next-state part
	// Channel k uses width slots 4k (delay high), 4k+1 (delay low)
	// and 4k+2 (output high); slot 4k+3 is stored only
	// Both channels share the stop decision, so hold on either
	// gate keeps both running
	always @*
	begin
		gate_d = gate_q;
		for (k = 0; k < 2; k = k + 1)
		begin
			st_d[k]     = st_q[k];
			lat_d[k]    = lat_q[k];
			cnt_d[k]    = cnt_q[k];
			hi_d[k]     = hi_q[k];
			pulses_d[k] = pulses_q[k];
			if (!mode_en || !run_q[k] || stop)
			begin
				// Stop drops the channel and its gate at once
				st_d[k]   = ST_IDLE;
				gate_d[k] = 1'b0;
			end
			else
			begin
				case (st_q[k])
					ST_IDLE:
					begin
						// Trigger active: begin start latency
						lat_d[k] = 2'd1;
						st_d[k]  = ST_START;
					end
					ST_START:
					begin
						// Latency spent: delay stage begins low
						if (lat_q[k] == `GD_START_LAT - 2'd1)
						begin
							st_d[k]     = ST_DLY;
							hi_d[k]     = 1'b0;
							cnt_d[k]    = width_q[4*k+1];
							pulses_d[k] = 2'd0;
						end
						else
							lat_d[k] = lat_q[k] + 2'd1;
					end
					ST_DLY:
					begin
						// Delay stage alternates low and high phases
						if (more_left(cnt_q[k]))
							cnt_d[k] = cnt_q[k] - CNT_ONE;
						else if (hi_q[k])
						begin
							// End of a high pulse: count it
							if (pulses_q[k] + 2'd1 == `GD_DLY_PULSES)
							begin
								st_d[k]   = ST_OUT;
								gate_d[k] = 1'b1;
								cnt_d[k]  = width_q[4*k+2];
							end
							else
							begin
								pulses_d[k] = pulses_q[k] + 2'd1;
								hi_d[k]     = 1'b0;
								cnt_d[k]    = width_q[4*k+1];
							end
						end
						else
						begin
							// End of a low phase: go high
							hi_d[k]  = 1'b1;
							cnt_d[k] = width_q[4*k];
						end
					end
					ST_OUT:
					begin
						// One output high period, then gate off
						// Channel waits here until the trigger drops
						if (more_left(cnt_q[k]))
							cnt_d[k] = cnt_q[k] - CNT_ONE;
						else
							gate_d[k] = 1'b0;
					end
					default: st_d[k] = ST_IDLE;
				endcase
			end
		end
	end

	// Channel sequencer registers
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			gate_q <= 2'b00;
			for (j = 0; j < 2; j = j + 1)
			begin
				st_q[j]     <= ST_IDLE;
				lat_q[j]    <= 2'd0;
				cnt_q[j]    <= {WIDTH{1'b0}};
				hi_q[j]     <= 1'b0;
				pulses_q[j] <= 2'd0;
			end
		end
		else
		begin
			gate_q <= gate_d;
			for (j = 0; j < 2; j = j + 1)
			begin
				st_q[j]     <= st_d[j];
				lat_q[j]    <= lat_d[j];
				cnt_q[j]    <= cnt_d[j];
				hi_q[j]     <= hi_d[j];
				pulses_q[j] <= pulses_d[j];
			end
		end
	end

	// Output stage: one extra register with polarity applied
	// This is the extra clock between gate and timer output pin
	// Polarity acts at once, even with the channel idle
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			gate_out0_o <= 1'b0;
			gate_out1_o <= 1'b0;
		end
		else
		begin
			gate_out0_o <= gate_q[0] ^ opol[0];
			gate_out1_o <= gate_q[1] ^ opol[1];
		end
	end

endmodule // gate_drive_pulse_mode

// File: verification/trig_src.sv
// Trigger source model driving the trigger pin.
// Assumes the bench clock; inv_i flips the level for low-active setups.
`timescale 1ns/1ns
module trig_src
(
	input  wire clk_i,
	input  wire act_i,
	input  wire inv_i,
	output reg  pin_o
);
	initial pin_o = 1'b0;
	// Pin follows the request one edge later
	always @(posedge clk_i)
		pin_o <= act_i ^ inv_i;
endmodule // trig_src

// File: verification/gate_drive_assertions.sv
// Port checker for the gate-drive block.
// Assumes the block's register map; bound to every instance.
`timescale 1ns/1ns
module gate_drive_chk
(
	input wire        clk_i,
	input wire        rst_n_i,
	input wire [3:0]  addr_i,
	input wire [15:0] wdata_i,
	input wire        wr_i,
	input wire        rd_i,
	input wire [15:0] rdata_o,
	input wire        trigger_input_pin_i,
	input wire        gate_out0_o,
	input wire        gate_out1_o
);
	reg  [7:0]  ctrl_q;
	reg  [15:0] oh_q;
	reg  [4:0]  age_q;
	reg  [15:0] run_q;
	reg  [3:0]  idle_q;
	wire        a0 = gate_out0_o ^ ctrl_q[2];
	wire        a1 = gate_out1_o ^ ctrl_q[3];
	wire        act = trigger_input_pin_i ^ ctrl_q[1];
	wire        quiet = age_q[4];
	// Shadow settings, settle age, active run, trigger idle run
	always @(posedge clk_i)
	begin
		if (!rst_n_i || wr_i) age_q <= 5'h00;
		else if (!quiet) age_q <= age_q + 5'h01;
		if (!rst_n_i) ctrl_q <= 8'h00;
		else if (wr_i && addr_i == 4'h0) ctrl_q <= wdata_i[7:0];
		if (!rst_n_i) oh_q <= 16'h0002;
		else if (wr_i && addr_i == 4'h3) oh_q <= wdata_i;
		run_q <= a0 ? run_q + 16'h0001 : 16'h0000;
		if (!rst_n_i || act) idle_q <= 4'h0;
		else idle_q <= idle_q + {3'h0, ~&idle_q};
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// Trigger seen inactive with no filtering and settled setup
	sequence drop_s;
		quiet && ctrl_q[6:4] == 3'h0 && !act;
	endsequence
	rd_zero_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
		else $error("read data not idle");
	ctrl_read_a: assert property (rd_i && addr_i == 4'h0 |=>
		rdata_o == {8'h00, ctrl_q}) else $error("control readback wrong");
	mode_off_a: assert property (quiet && !ctrl_q[0] |-> !a0 && !a1)
		else $error("gate active outside gate mode");
	trig_stop_a: assert property (quiet && !ctrl_q[7] &&
		ctrl_q[6:4] == 3'h0 && idle_q > 4'h6 |-> !a0 && !a1)
		else $error("gate active after trigger left");
	dly_stop0_a: assert property (drop_s |-> ##6 (!$rose(a0)) [*2])
		else $error("gate 0 rose after drop in delay");
	dly_stop1_a: assert property (drop_s |-> ##6 (!$rose(a1)) [*2])
		else $error("gate 1 rose after drop in delay");
	out_len_a: assert property (quiet && a0 |-> run_q < oh_q)
		else $error("gate 0 window too long");
	hold_keep_a: assert property (quiet && ctrl_q[7] && a0 &&
		run_q + 16'h0001 < oh_q |=> a0) else $error("held gate dropped");
endmodule // gate_drive_chk
bind gate_drive_pulse_mode gate_drive_chk gate_drive_chk_inst (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.trigger_input_pin_i(trigger_input_pin_i),
	.gate_out0_o(gate_out0_o), .gate_out1_o(gate_out1_o));

// File: verification/tb_gate_drive_pulse_mode.sv
// Bench: registers, delay chain, stop, hold and polarity.
// Assumes the block's register map and the trigger source model.
`timescale 1ns/1ns
module tb_gate_drive_pulse_mode;
	reg         clk_i = 1'b0;
	reg         rst_n_i = 1'b0;
	reg  [3:0]  addr_i = 4'h0;
	reg  [15:0] wdata_i = 16'h0000;
	reg         wr_i = 1'b0;
	reg         rd_i = 1'b0;
	reg         act = 1'b0;
	reg         inv = 1'b0;
	wire [15:0] rdata_o;
	wire        pin;
	wire        g0;
	wire        g1;
	integer     fail_count = 0;
	integer     checked = 0;
	integer     c;
	always #10 clk_i = ~clk_i;
	trig_src trig_src_inst (.clk_i(clk_i), .act_i(act), .inv_i(inv),
		.pin_o(pin));
	gate_drive_pulse_mode gate_drive_pulse_mode_inst (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .trigger_input_pin_i(pin),
		.gate_out0_o(g0), .gate_out1_o(g1));
	task final_report;
	begin
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	task chk(input [15:0] seen, input [15:0] exp);
	begin
		checked = checked + 1;
		if (seen !== exp)
		begin
			fail_count = fail_count + 1;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	end
	endtask
	task wr(input [3:0] a, input [15:0] d);
	begin
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	end
	endtask
	task rdc(input [3:0] a, input [15:0] e);
	begin
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		chk(rdata_o, e);
	end
	endtask
	// Bounded wait for gate 0 level v, cycles counted in c
	task wgate(input v);
	begin
		c = 0;
		while (g0 !== v && c < 80)
		begin
			@(negedge clk_i);
			c = c + 1;
		end
		if (c >= 80)
		begin
			fail_count = fail_count + 1;
			final_report;
		end
	end
	endtask
	task trig(input v);
	begin
		@(posedge clk_i);
		act <= v;
	end
	endtask
	// Stop, set mode, widths, then start both channels
	task cfg(input [7:0] m, input [15:0] oh);
	begin
		wr(4'h9, 16'h0000);
		wr(4'h0, {8'h00, m});
		wr(4'h1, 16'h0001);
		wr(4'h2, 16'h0002);
		wr(4'h3, oh);
		wr(4'h5, 16'h0001);
		wr(4'h6, 16'h0002);
		wr(4'h7, 16'h0003);
		wr(4'h9, 16'h0003);
	end
	endtask
	task t_regs;
	begin
		rdc(4'h0, 16'h0000);
		rdc(4'h1, 16'h0002);
		rdc(4'hb, 16'h0000);
		rdc(4'ha, 16'h0000);
		wr(4'h0, 16'hff8f);
		rdc(4'h0, 16'h008f);
	end
	endtask
	task t_pulse;
	begin
		cfg(8'h01, 16'h0005);
		trig(1'b1);
		wgate(1'b1);
		chk(c >= 13 && c <= 14, 1);
		chk(g1, 1);
		wgate(1'b0);
		chk(c, 5);
		trig(1'b0);
		trig(1'b1);
		repeat (4) @(posedge clk_i);
		trig(1'b0);
		c = 0;
		repeat (30) @(negedge clk_i) c = c + (g0 !== 1'b0);
		chk(c, 0);
	end
	endtask
	task t_stop(input [7:0] m, input [15:0] lo, input [15:0] hi);
	begin
		cfg(m, 16'h0028);
		trig(1'b1);
		wgate(1'b1);
		trig(1'b0);
		wgate(1'b0);
		chk(c >= lo && c <= hi, 1);
		repeat (10) @(posedge clk_i);
	end
	endtask
	// Width code 001: later start, and a 3-cycle glitch is ignored
	task t_filt;
	begin
		cfg(8'h11, 16'h0005);
		trig(1'b1);
		wgate(1'b1);
		chk(c >= 16 && c <= 17, 1);
		trig(1'b0);
		repeat (20) @(posedge clk_i);
		trig(1'b1);
		repeat (2) @(posedge clk_i);
		trig(1'b0);
		c = 0;
		repeat (40) @(negedge clk_i) c = c + (g0 !== 1'b0);
		chk(c, 0);
	end
	endtask
	task t_pol;
	begin
		inv <= 1'b1;
		cfg(8'h0f, 16'h0028);
		repeat (4) @(negedge clk_i);
		chk({g1, g0}, 2'h3);
		trig(1'b1);
		wgate(1'b0);
		chk(c >= 13 && c <= 14, 1);
		wgate(1'b1);
		chk(c, 40);
	end
	endtask
	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_regs;
		t_pulse;
		t_stop(8'h01, 7, 7);
		t_stop(8'h81, 40, 40);
		t_filt;
		t_pol;
		final_report;
	end
endmodule // tb_gate_drive_pulse_mode
